// ---- rtl/console_pkg.sv ----
// Console panel package: APB register map, fields, codes, timing.
// Assumes a single 200 MHz clock and octal function codes of six bits.
package console_pkg;
  // APB byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_DSEL = 12'h008;
  localparam logic [11:0] OFF_DVAL = 12'h00c;
  // Control fields (commands are write pulses)
  localparam int CTL_START_POS = 0;
  localparam int CTL_STEP_POS = 1;
  localparam int CTL_MCLR_POS = 2;
  localparam int CTL_CLRFLT_POS = 3;
  localparam int CTL_BPEN_POS = 4;
  localparam logic CTL_BPEN_RST = 1'b1;
  // Status fields
  localparam int ST_HALT_POS = 0;
  localparam int ST_CAUSE_POS = 1;
  localparam int ST_ARITH_POS = 4;
  localparam int ST_ODD_POS = 8;
  localparam int ST_EVEN_POS = 9;
  localparam int ST_DEEP_POS = 10;
  // Arithmetic fault bit order
  localparam int FLT_DIV = 0;
  localparam int FLT_SHIFT = 1;
  localparam int FLT_OVF = 2;
  localparam int FLT_EXP = 3;
  // Function codes (octal)
  localparam logic [5:0] ILL_LO_OP = 6'h00;
  localparam logic [5:0] ILL_HI_OP = 6'h3f;
  localparam logic [5:0] SEL_STOP_OP = 6'h3e;
  // Arithmetic limits
  localparam logic [11:0] SHIFT_MAX = 12'h07f;
  localparam logic [11:0] EXP_LIMIT = 12'h400;
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int STEP_LIMIT_US = 1000;
  localparam int STEP_LIMIT_CYC = STEP_LIMIT_US * CLK_MHZ;
  // Run control states, Gray along halt-run and halt-step
  typedef enum logic [1:0] {
    HALTED = 2'h0,
    RUNNING = 2'h1,
    STEPPING = 2'h2
  } run_state_t;
  typedef enum logic [2:0] {
    CAUSE_NONE = 3'h0,
    CAUSE_ILLEGAL = 3'h1,
    CAUSE_SELSTOP = 3'h2,
    CAUSE_BREAK = 3'h3,
    CAUSE_STEP = 3'h4,
    CAUSE_MCLR = 3'h5
  } halt_cause_t;
endpackage : console_pkg

// ---- rtl/disp_if.sv ----
// Carrier between panel control and the octal lamp driver.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface disp_if #(parameter int NREG = 4, parameter int REG_W = 24);
  localparam int ND = (REG_W + 2) / 3;
  logic [NREG-1:0][REG_W-1:0] value;
  logic halted;
  logic [NREG-1:0][ND-1:0][2:0] digit;
  logic blank;
  modport drv(input value, input halted, output digit, output blank);
  modport user(output value, output halted, input digit, input blank);
endinterface : disp_if
`default_nettype wire

// ---- rtl/octal_lamp_driver.sv ----
// Octal lamp driver: three bits per digit, one register stage, blank while running.
// Assumes register values are stable whenever the machine is halted.
`timescale 1ns/1ps
`default_nettype none
module octal_lamp_driver #(parameter int NREG = 4, parameter int REG_W = 24) (
  input wire logic mclk,
  input wire logic nrst,
  disp_if.drv d
);
  localparam int ND = (REG_W + 2) / 3;
  typedef struct packed {
    logic [NREG-1:0][ND-1:0][2:0] digit;
    logic blank;
  } lamp_state_t;
  lamp_state_t q, n;

  always_comb begin
    n = q;
    n.blank = ~d.halted;
    for (int r = 0; r < NREG; r++) begin
      for (int i = 0; i < ND; i++) begin
        for (int b = 0; b < 3; b++) begin
          if (3 * i + b < REG_W) begin
            n.digit[r][i][b] = d.halted & d.value[r][3*i+b];
          end else begin
            n.digit[r][i][b] = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q <= '{digit: '0, blank: 1'b1};
    end else begin
      q <= n;
    end
  end

  assign d.digit = q.digit;
  assign d.blank = q.blank;
endmodule : octal_lamp_driver
`default_nettype wire

// ---- rtl/console_register_panel.sv ----
// Operator console panel: register forcing, octal display, stop control, lights.
// Assumes processor handshakes are synchronous to mclk; APB slave, no wait states.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module console_register_panel #(
  parameter int NREG = 4,
  parameter int REG_W = 24,
  parameter int STEP_LIMIT_CYC = console_pkg::STEP_LIMIT_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start_sw,
  input wire logic step_sw,
  input wire logic clear_sw,
  input wire logic [2:0] sel_stop_sw,
  input wire logic [14:0] bp_sw,
  input wire logic mode_sweep,
  input wire logic [NREG-1:0][REG_W-1:0] set_btn,
  input wire logic [NREG-1:0] clr_btn,
  input wire logic [NREG-1:0][REG_W-1:0] reg_val,
  input wire logic op_issue,
  input wire logic [5:0] op_code,
  input wire logic [2:0] op_desig,
  input wire logic upper_instr,
  input wire logic [14:0] prog_addr,
  input wire logic op_done,
  input wire logic buf_pending,
  input wire logic lower_shown,
  input wire logic int_routine,
  input wire logic int_request,
  input wire logic [2:0] chan_in_busy,
  input wire logic [2:0] chan_out_busy,
  input wire logic reader_at_load,
  input wire logic reader_buf,
  input wire logic punch_low,
  input wire logic odd_seq_fault,
  input wire logic even_seq_fault,
  input wire logic div_bad,
  input wire logic shift_issue,
  input wire logic [11:0] shift_cnt,
  input wire logic addsub_ovf,
  input wire logic fp_done,
  input wire logic [11:0] fp_exp,
  output logic exec_ok,
  output logic run_en,
  output logic mclr_out,
  output logic [NREG-1:0][REG_W-1:0] force_set,
  output logic [NREG-1:0] force_clr,
  output logic odd_bank_inop,
  output logic even_bank_inop,
  output logic [NREG-1:0][(REG_W+2)/3-1:0][2:0] digit_lamp,
  output logic digit_blank,
  output logic lockout_lamp,
  output logic int_req_lamp,
  output logic [5:0] chan_lamp,
  output logic reader_lamp,
  output logic punch_lamp,
  output logic odd_fault_lamp,
  output logic even_fault_lamp,
  output logic [3:0] arith_lamp,
  output logic deep_end_lamp,
  output logic lower_lamp,
  output logic [2:0] sweep_lamp
);
  localparam int CW = $clog2(STEP_LIMIT_CYC + 1);
  localparam int SW = (NREG > 1) ? $clog2(NREG) : 1;
  localparam int ND = (REG_W + 2) / 3;

  typedef struct packed {
    console_pkg::run_state_t st;
    console_pkg::halt_cause_t cause;
    logic issued;
    logic done_seen;
    logic [CW-1:0] step_cnt;
    logic deep_end;
    logic [3:0] arith;
    logic odd_f;
    logic even_f;
    logic bp_en;
    logic [SW-1:0] dsel;
    logic mclr;
    logic [NREG-1:0][REG_W-1:0] fset;
    logic [NREG-1:0] fclr;
    logic lockout;
    logic int_req;
    logic [5:0] chan;
    logic reader;
    logic punch;
    logic lower;
    logic [2:0] sweep;
  } panel_state_t;

  panel_state_t q, d;
  disp_if #(.NREG(NREG), .REG_W(REG_W)) dbus ();

  function automatic console_pkg::halt_cause_t stop_cause(
    input logic [5:0] code, input logic [2:0] b, input logic [2:0] ss, input logic bp_hit);
    stop_cause = console_pkg::CAUSE_NONE;
    if (code == console_pkg::ILL_LO_OP || code == console_pkg::ILL_HI_OP) begin
      stop_cause = console_pkg::CAUSE_ILLEGAL;
    end else if (code == console_pkg::SEL_STOP_OP && b[1:0] != 2'h0 && ss[b[1:0] - 2'h1]) begin
      stop_cause = console_pkg::CAUSE_SELSTOP;
    end else if (bp_hit) begin
      stop_cause = console_pkg::CAUSE_BREAK;
    end
  endfunction : stop_cause

  logic apb_wr;
  logic ctl_wr;
  logic start_go;
  logic step_go;
  logic mclr_go;
  logic clrflt_go;
  logic bp_hit;
  logic may_issue;
  logic [3:0] arith_set;
  console_pkg::halt_cause_t cause_now;

  assign apb_wr = psel & penable & pwrite;
  assign ctl_wr = apb_wr & (paddr == console_pkg::OFF_CTRL);
  assign start_go = start_sw | (ctl_wr & pwdata[console_pkg::CTL_START_POS]);
  assign step_go = step_sw | (ctl_wr & pwdata[console_pkg::CTL_STEP_POS]);
  assign mclr_go = clear_sw | (ctl_wr & pwdata[console_pkg::CTL_MCLR_POS]);
  assign clrflt_go = ctl_wr & pwdata[console_pkg::CTL_CLRFLT_POS];
  assign bp_hit = q.bp_en & upper_instr & (prog_addr == bp_sw);
  assign cause_now = stop_cause(op_code, op_desig, sel_stop_sw, bp_hit);
  assign may_issue = (q.st == console_pkg::RUNNING)
                   | ((q.st == console_pkg::STEPPING) & ~q.issued);
  assign exec_ok = op_issue & may_issue & ~mclr_go
                 & (cause_now == console_pkg::CAUSE_NONE);

  always_comb begin
    arith_set = '0;
    arith_set[console_pkg::FLT_DIV] = div_bad;
    arith_set[console_pkg::FLT_SHIFT] = shift_issue & (shift_cnt > console_pkg::SHIFT_MAX);
    arith_set[console_pkg::FLT_OVF] = addsub_ovf;
    arith_set[console_pkg::FLT_EXP] = fp_done & (fp_exp >= console_pkg::EXP_LIMIT);
  end

  always_comb begin
    d = q;
    d.mclr = 1'b0;
    d.fset = set_btn;
    d.fclr = clr_btn;
    d.lockout = int_routine;
    d.int_req = int_request;
    for (int c = 0; c < 3; c++) begin
      d.chan[2*c] = chan_in_busy[c];
      d.chan[2*c+1] = chan_out_busy[c];
    end
    d.reader = reader_at_load | reader_buf;
    d.punch = punch_low;
    d.lower = lower_shown;
    d.sweep = {3{mode_sweep}};
    d.arith = (q.arith & ~{4{clrflt_go | mclr_go}}) | arith_set;
    d.odd_f = (q.odd_f & ~mclr_go) | odd_seq_fault;
    d.even_f = (q.even_f & ~mclr_go) | even_seq_fault;
    if (ctl_wr) begin
      d.bp_en = pwdata[console_pkg::CTL_BPEN_POS];
    end
    if (apb_wr && paddr == console_pkg::OFF_DSEL) begin
      d.dsel = pwdata[SW-1:0];
    end
    case (q.st)
      console_pkg::HALTED: begin
        if (step_go) begin
          d.st = console_pkg::STEPPING;
          d.issued = 1'b0;
          d.done_seen = 1'b0;
          d.step_cnt = '0;
          d.deep_end = 1'b0;
          d.cause = console_pkg::CAUSE_NONE;
        end else if (start_go) begin
          d.st = console_pkg::RUNNING;
          d.cause = console_pkg::CAUSE_NONE;
        end
      end
      console_pkg::RUNNING: begin
        if (op_issue && cause_now != console_pkg::CAUSE_NONE) begin
          d.st = console_pkg::HALTED;
          d.cause = cause_now;
        end else if (step_go) begin
          d.st = console_pkg::STEPPING;
          d.issued = 1'b1;
          d.done_seen = 1'b0;
          d.step_cnt = '0;
          d.deep_end = 1'b0;
        end
      end
      console_pkg::STEPPING: begin
        if (q.step_cnt == CW'(STEP_LIMIT_CYC - 1)) begin
          d.deep_end = 1'b1;
        end else begin
          d.step_cnt = q.step_cnt + CW'(1);
        end
        if (op_issue && !q.issued) begin
          if (cause_now != console_pkg::CAUSE_NONE) begin
            d.st = console_pkg::HALTED;
            d.cause = cause_now;
          end else begin
            d.issued = 1'b1;
          end
        end else if (q.issued && (op_done || q.done_seen)) begin
          d.done_seen = 1'b1;
          if (!buf_pending) begin
            d.st = console_pkg::HALTED;
            d.cause = console_pkg::CAUSE_STEP;
          end
        end
      end
      default: begin
        d.st = console_pkg::HALTED;
      end
    endcase
    if (mclr_go) begin
      d.st = console_pkg::HALTED;
      d.cause = console_pkg::CAUSE_MCLR;
      d.mclr = 1'b1;
      d.fclr = '1;
      d.deep_end = 1'b0;
      d.issued = 1'b0;
      d.done_seen = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q <= '{st: console_pkg::HALTED, cause: console_pkg::CAUSE_NONE,
             bp_en: console_pkg::CTL_BPEN_RST, default: '0};
    end else begin
      q <= d;
    end
  end

  assign dbus.value = reg_val;
  assign dbus.halted = (q.st == console_pkg::HALTED);

  octal_lamp_driver #(.NREG(NREG), .REG_W(REG_W)) u_lamps (
    .mclk(mclk),
    .nrst(nrst),
    .d(dbus.drv)
  );

  // APB read side, zero wait states
  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr != console_pkg::OFF_CTRL)
                 & (paddr != console_pkg::OFF_STATUS) & (paddr != console_pkg::OFF_DSEL)
                 & (paddr != console_pkg::OFF_DVAL);

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      console_pkg::OFF_CTRL: prdata[console_pkg::CTL_BPEN_POS] = q.bp_en;
      console_pkg::OFF_STATUS: begin
        prdata[console_pkg::ST_HALT_POS] = (q.st == console_pkg::HALTED);
        prdata[console_pkg::ST_CAUSE_POS +: 3] = q.cause;
        prdata[console_pkg::ST_ARITH_POS +: 4] = q.arith;
        prdata[console_pkg::ST_ODD_POS] = q.odd_f;
        prdata[console_pkg::ST_EVEN_POS] = q.even_f;
        prdata[console_pkg::ST_DEEP_POS] = q.deep_end;
      end
      console_pkg::OFF_DSEL: prdata[SW-1:0] = q.dsel;
      console_pkg::OFF_DVAL: prdata = 32'(dbus.digit[q.dsel]);
      default: prdata = 32'h0000_0000;
    endcase
  end

  assign run_en = may_issue;
  assign mclr_out = q.mclr;
  assign force_set = q.fset;
  assign force_clr = q.fclr;
  assign odd_bank_inop = q.odd_f;
  assign even_bank_inop = q.even_f;
  assign digit_lamp = dbus.digit;
  assign digit_blank = dbus.blank;
  assign lockout_lamp = q.lockout;
  assign int_req_lamp = q.int_req;
  assign chan_lamp = q.chan;
  assign reader_lamp = q.reader;
  assign punch_lamp = q.punch;
  assign odd_fault_lamp = q.odd_f;
  assign even_fault_lamp = q.even_f;
  assign arith_lamp = q.arith;
  assign deep_end_lamp = q.deep_end;
  assign lower_lamp = q.lower;
  assign sweep_lamp = q.sweep;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_step_taken;
    (q.st == console_pkg::STEPPING) && exec_ok;
  endsequence
  sequence s_step_drained;
    (q.st == console_pkg::STEPPING) && q.issued && op_done && !buf_pending && !mclr_go;
  endsequence

  chk_illegal_halt: assert property ((q.st == console_pkg::RUNNING) && op_issue && !mclr_go
      && (op_code == 6'h00 || op_code == 6'h3f)
      |-> !exec_ok ##1 (q.st == console_pkg::HALTED && q.cause == console_pkg::CAUSE_ILLEGAL))
    else $error("illegal code did not halt");
  chk_selstop_halt: assert property ((q.st == console_pkg::RUNNING) && op_issue && !mclr_go
      && op_code == 6'h3e && op_desig == 3'h1 && sel_stop_sw[0]
      |=> q.st == console_pkg::HALTED)
    else $error("selective stop ignored");
  chk_bp_halt: assert property (op_issue && bp_hit && may_issue |-> !exec_ok)
    else $error("breakpoint instruction executed");
  chk_single_step: assert property (s_step_taken |=> !run_en)
    else $error("second instruction allowed in step");
  chk_step_end: assert property (s_step_drained |=> q.st == console_pkg::HALTED ##1 !run_en)
    else $error("step did not halt");
  chk_blank_run: assert property ((q.st != console_pkg::HALTED) |=> digit_blank)
    else $error("display lit while running");
  chk_shift_fault: assert property (shift_issue && shift_cnt > 12'h07f |=> arith_lamp[1])
    else $error("shift fault missed");
  chk_exp_fault: assert property (fp_done && fp_exp >= 12'h400 |=> arith_lamp[3])
    else $error("exponent fault missed");
  chk_fault_hold: assert property (arith_lamp[0] && !mclr_go && !clrflt_go |=> arith_lamp[0])
    else $error("divide fault lost");
  chk_bank_hold: assert property (odd_bank_inop && !mclr_go |=> $stable(odd_bank_inop))
    else $error("odd bank fault lost");
  chk_clear_button: assert property (clr_btn[0] |=> force_clr[0])
    else $error("clear button not forwarded");
endmodule : console_register_panel
`default_nettype wire

// ---- tb/cpu_model.sv ----
// Processor stand-in: issues one instruction at a time while allowed to run.
// Assumes the panel grants an issue with exec_ok in the cycle of op_issue.
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic run_en,
  input wire logic exec_ok,
  input wire logic [5:0] code,
  input wire logic [2:0] desig,
  input wire logic upper,
  input wire logic [14:0] addr,
  input wire logic [7:0] lat,
  output logic op_issue,
  output logic [5:0] op_code,
  output logic [2:0] op_desig,
  output logic upper_instr,
  output logic [14:0] prog_addr,
  output logic op_done
);
  logic busy;
  logic [7:0] cnt;
  // Fields hold no meaning outside an issue cycle
  assign op_code = op_issue ? code : ~code;
  assign op_desig = op_issue ? desig : ~desig;
  assign upper_instr = op_issue ? upper : ~upper;
  assign prog_addr = op_issue ? addr : ~addr;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      op_issue <= 1'b0;
      op_done <= 1'b0;
      busy <= 1'b0;
      cnt <= 8'h00;
    end else begin
      op_done <= 1'b0;
      if (busy) begin
        cnt <= cnt + 8'h01;
        if (cnt >= lat) begin
          busy <= 1'b0;
          op_done <= 1'b1;
        end
      end else if (op_issue && exec_ok) begin
        op_issue <= 1'b0;
        busy <= 1'b1;
        cnt <= 8'h00;
      end else begin
        op_issue <= run_en;
      end
    end
  end
endmodule : cpu_model
`default_nettype wire

// ---- tb/console_register_panel_tb_top.sv ----
// Console panel bench: APB tasks, switch pulses, processor stand-in.
// Assumes the panel package and a step limit of 20 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH %0t %s", $time, m); end end
module console_register_panel_tb_top;
  logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0, shift_cnt = '0, fp_exp = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, mclr_out, exec_ok, run_en, op_issue, op_done;
  logic start_sw = 1'b0, step_sw = 1'b0, clear_sw = 1'b0, mode_sweep = 1'b0;
  logic buf_pending = 1'b0, upper = 1'b0, upper_instr, lower_shown = 1'b0;
  logic int_routine = 1'b0, int_request = 1'b0, reader_at_load = 1'b0;
  logic reader_buf = 1'b0, punch_low = 1'b0, odd_seq_fault = 1'b0;
  logic even_seq_fault = 1'b0, div_bad = 1'b0, shift_issue = 1'b0;
  logic addsub_ovf = 1'b0, fp_done = 1'b0;
  logic [2:0] sel_stop_sw = '0, desig = '0, chan_in_busy = '0, chan_out_busy = '0;
  logic [2:0] op_desig, sweep_lamp;
  logic [14:0] bp_sw = '0, addr = '0, prog_addr;
  logic [3:0][23:0] set_btn = '0, reg_val = '0, force_set;
  logic [3:0][7:0][2:0] digit_lamp;
  logic [3:0] clr_btn = '0, force_clr, arith_lamp;
  logic [5:0] code = 6'h10, op_code, chan_lamp;
  logic [7:0] lat = 8'h02;
  logic [12:0] lin;
  logic odd_bank_inop, even_bank_inop, digit_blank, lockout_lamp, int_req_lamp;
  logic reader_lamp, punch_lamp, odd_fault_lamp, even_fault_lamp, deep_end_lamp, lower_lamp;
  int mismatches = 0, num_checks = 0, cyc = 0, n_exec = 0, n_mclr = 0, k;

  console_register_panel #(.NREG(4), .REG_W(24), .STEP_LIMIT_CYC(20)) DUT (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_sw(start_sw), .step_sw(step_sw), .clear_sw(clear_sw), .sel_stop_sw(sel_stop_sw),
    .bp_sw(bp_sw), .mode_sweep(mode_sweep), .set_btn(set_btn), .clr_btn(clr_btn),
    .reg_val(reg_val), .op_issue(op_issue), .op_code(op_code), .op_desig(op_desig),
    .upper_instr(upper_instr), .prog_addr(prog_addr), .op_done(op_done),
    .buf_pending(buf_pending), .lower_shown(lower_shown), .int_routine(int_routine),
    .int_request(int_request), .chan_in_busy(chan_in_busy), .chan_out_busy(chan_out_busy),
    .reader_at_load(reader_at_load), .reader_buf(reader_buf), .punch_low(punch_low),
    .odd_seq_fault(odd_seq_fault), .even_seq_fault(even_seq_fault), .div_bad(div_bad),
    .shift_issue(shift_issue), .shift_cnt(shift_cnt), .addsub_ovf(addsub_ovf),
    .fp_done(fp_done), .fp_exp(fp_exp), .exec_ok(exec_ok), .run_en(run_en),
    .mclr_out(mclr_out), .force_set(force_set), .force_clr(force_clr),
    .odd_bank_inop(odd_bank_inop), .even_bank_inop(even_bank_inop),
    .digit_lamp(digit_lamp), .digit_blank(digit_blank), .lockout_lamp(lockout_lamp),
    .int_req_lamp(int_req_lamp), .chan_lamp(chan_lamp), .reader_lamp(reader_lamp),
    .punch_lamp(punch_lamp), .odd_fault_lamp(odd_fault_lamp),
    .even_fault_lamp(even_fault_lamp), .arith_lamp(arith_lamp),
    .deep_end_lamp(deep_end_lamp), .lower_lamp(lower_lamp), .sweep_lamp(sweep_lamp)
  );
  cpu_model cpu (
    .mclk(mclk), .nrst(nrst), .run_en(run_en), .exec_ok(exec_ok), .code(code),
    .desig(desig), .upper(upper), .addr(addr), .lat(lat), .op_issue(op_issue),
    .op_code(op_code), .op_desig(op_desig), .upper_instr(upper_instr),
    .prog_addr(prog_addr), .op_done(op_done)
  );

  initial begin
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
  end
  always @(posedge mclk) begin
    cyc++;
    if (op_issue && exec_ok) n_exec++;
    if (mclr_out) n_mclr++;
    if (cyc == 5000) begin
      mismatches++;
      close_out;
    end
  end

  task close_out;
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task st(input logic [2:0] c);
    apb(1'b0, console_pkg::OFF_STATUS, '0);
    `CHK(rd[3:0], {c, 1'b1}, "halt status")
  endtask : st
  task run_chk;
    apb(1'b0, console_pkg::OFF_STATUS, '0);
    `CHK(rd[0], 1'b0, "not running")
  endtask : run_chk
  task sw(input int s);
    @(posedge mclk);
    if (s == 0) start_sw <= 1'b1;
    else if (s == 1) step_sw <= 1'b1;
    else clear_sw <= 1'b1;
    @(posedge mclk);
    {start_sw, step_sw, clear_sw} <= 3'h0;
  endtask : sw
  task ev(input int e, input logic [11:0] v);
    @(posedge mclk);
    case (e)
      0: div_bad <= 1'b1;
      1: {shift_issue, shift_cnt} <= {1'b1, v};
      2: addsub_ovf <= 1'b1;
      3: {fp_done, fp_exp} <= {1'b1, v};
      4: odd_seq_fault <= 1'b1;
      default: even_seq_fault <= 1'b1;
    endcase
    @(posedge mclk);
    {div_bad, shift_issue, addsub_ovf, fp_done, odd_seq_fault, even_seq_fault} <= 6'h00;
    tick(2);
  endtask : ev

  initial begin
    @(posedge nrst);
    apb(1'b0, console_pkg::OFF_CTRL, '0);
    `CHK(rd[4], console_pkg::CTL_BPEN_RST, "bp enable reset")
    st(console_pkg::CAUSE_NONE);
    apb(1'b1, 12'h010, 32'hffffffff);
    `CHK(err, 1'b1, "unmapped error")
    apb(1'b0, 12'h010, '0);
    `CHK(rd, 32'h00000000, "unmapped read")
    set_btn[1] <= 24'h800005;
    tick(2);
    `CHK(force_set, set_btn, "set buttons")
    set_btn <= '0;
    clr_btn <= 4'h5;
    tick(2);
    `CHK(force_clr, 4'h5, "clear button")
    clr_btn <= '0;
    reg_val <= {24'h053977, 24'hfac688, 24'he38e38, 24'h28a28a};
    tick(3);
    `CHK(digit_lamp, reg_val, "digits")
    `CHK(digit_blank, 1'b0, "blank halted")
    apb(1'b1, console_pkg::OFF_DSEL, 32'h2);
    apb(1'b0, console_pkg::OFF_DVAL, '0);
    `CHK(rd, {8'h00, reg_val[2]}, "dval")
    sw(0);
    tick(3);
    `CHK(digit_blank, 1'b1, "blank running")
    `CHK(digit_lamp, 96'h0, "digits running")
    for (int i = 0; i < 14; i++) begin
      lin = (i < 13) ? 13'h1 << i : 13'h0;
      {int_routine, int_request, chan_out_busy, chan_in_busy, reader_at_load, reader_buf,
       punch_low, lower_shown, mode_sweep} <= lin;
      tick(2);
      `CHK({lockout_lamp, int_req_lamp, chan_lamp, reader_lamp, punch_lamp, lower_lamp,
            sweep_lamp}, {lin[12:11], lin[10], lin[7], lin[9], lin[6], lin[8], lin[5],
            lin[4] | lin[3], lin[2:1], {3{lin[0]}}}, "lights")
    end
    bp_sw <= 15'h1234;
    addr <= 15'h1234;
    tick(8);
    run_chk;
    upper <= 1'b1;
    tick(8);
    st(console_pkg::CAUSE_BREAK);
    upper <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      code <= i ? console_pkg::ILL_HI_OP : console_pkg::ILL_LO_OP;
      sw(0);
      tick(8);
      st(console_pkg::CAUSE_ILLEGAL);
    end
    code <= console_pkg::SEL_STOP_OP;
    desig <= 3'h6;
    sel_stop_sw <= 3'h1;
    sw(0);
    tick(8);
    run_chk;
    sel_stop_sw <= 3'h2;
    tick(8);
    st(console_pkg::CAUSE_SELSTOP);
    desig <= 3'h1;
    sel_stop_sw <= 3'h1;
    apb(1'b1, console_pkg::OFF_CTRL, 32'h11);
    tick(8);
    st(console_pkg::CAUSE_SELSTOP);
    code <= 6'h10;
    sw(0);
    ev(1, 12'h07f);
    ev(3, 12'h3ff);
    `CHK(arith_lamp, 4'h0, "no fault at limits")
    ev(0, '0);
    ev(1, 12'h080);
    ev(2, '0);
    ev(3, 12'h400);
    `CHK(arith_lamp, 4'hf, "arith faults")
    ev(4, '0);
    ev(5, '0);
    `CHK({odd_fault_lamp, even_fault_lamp, odd_bank_inop, even_bank_inop}, 4'hf, "bank")
    apb(1'b1, console_pkg::OFF_CTRL, 32'h18);
    tick(2);
    `CHK(arith_lamp, 4'h0, "arith cleared")
    `CHK(odd_fault_lamp, 1'b1, "bank kept")
    sw(2);
    tick(3);
    st(console_pkg::CAUSE_MCLR);
    `CHK(n_mclr, 1, "mclr pulse")
    `CHK({odd_fault_lamp, even_fault_lamp, odd_bank_inop, even_bank_inop}, 4'h0, "mclr")
    lat <= 8'd60;
    buf_pending <= 1'b1;
    k = n_exec;
    sw(1);
    tick(30);
    `CHK(deep_end_lamp, 1'b1, "deep end")
    `CHK(run_en, 1'b0, "one step")
    tick(40);
    run_chk;
    `CHK(n_exec, k + 1, "one instruction")
    buf_pending <= 1'b0;
    tick(3);
    st(console_pkg::CAUSE_STEP);
    lat <= 8'h02;
    code <= 6'h10;
    desig <= 3'h0;
    addr <= 15'h0001;
    sw(1);
    tick(10);
    st(console_pkg::CAUSE_STEP);
    `CHK(deep_end_lamp, 1'b0, "deep end cleared")
    code <= 6'h3c;
    desig <= 3'h1;
    addr <= 15'h0200;
    sw(1);
    tick(10);
    st(console_pkg::CAUSE_STEP);
    `CHK(n_exec, k + 3, "loader steps")
    close_out;
  end
endmodule : console_register_panel_tb_top
`default_nettype wire
